// [rtl/flh_pkg.sv]
// Constants, field layouts and time conversions for the fault history logger.
// Assumes a single 40 MHz clock; times are kept as linear minute counts, session and total uptime as tenth-hour counts.
package flh_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int TRIP_DEPTH = 10;
  localparam int SLOTS      = 3;
  localparam int CODE_W     = 8;
  localparam int MIN_W      = 32;
  localparam int FIELD_W    = 16;
  localparam int YEAR_W     = 7;
  localparam int DAY_W      = 9;
  localparam int HOUR_W     = 8;
  localparam int MINF_W     = 8;
  localparam int IVH_W      = 10;
  localparam int IVM_W      = 6;

  // ****************************************
  // Time constants
  // ****************************************
  localparam logic [63:0] CLK_HZ      = 64'h0000_0000_0262_5A00;
  localparam logic [63:0] SEC_PER_MIN = 64'h0000_0000_0000_003C;
  localparam logic [63:0] CYC_PER_MIN = CLK_HZ * SEC_PER_MIN;
  localparam logic [MIN_W-1:0] MIN_PER_HOUR  = 32'h0000_003C;
  localparam logic [MIN_W-1:0] HOURS_PER_DAY = 32'h0000_0018;
  localparam logic [MIN_W-1:0] MIN_PER_DAY   = 32'h0000_05A0;
  localparam logic [MIN_W-1:0] DAYS_PER_YEAR = 32'h0000_016D;
  localparam logic [MIN_W-1:0] SAT_HOURS     = 32'h0000_0258;
  localparam logic [MIN_W-1:0] SAT_MIN       = SAT_HOURS * MIN_PER_HOUR;
  localparam logic [2:0]       MIN_PER_TENTH = 3'h6;

  // ****************************************
  // Parameter map for slot error codes
  // ****************************************
  localparam logic [7:0] MENU_SLOT1 = 8'h0F;
  localparam logic [7:0] MENU_SLOT2 = 8'h10;
  localparam logic [7:0] MENU_SLOT3 = 8'h11;
  localparam logic [7:0] PARAM_ERR  = 8'h32;

  typedef enum logic [0:0] {
    ST_WAIT_NV = 1'b0,
    ST_RUN     = 1'b1
  } flh_state_e;

  // Years in upper bits, days of year below
  function automatic logic [FIELD_W-1:0] ydField(input logic [MIN_W-1:0] m);
    logic [MIN_W-1:0] d;
    d = m / MIN_PER_DAY;
    return {YEAR_W'(d / DAYS_PER_YEAR), DAY_W'(d % DAYS_PER_YEAR)};
  endfunction

  // Hours of day in upper byte, minutes below
  function automatic logic [FIELD_W-1:0] hmField(input logic [MIN_W-1:0] m);
    logic [MIN_W-1:0] h;
    h = (m / MIN_PER_HOUR) % HOURS_PER_DAY;
    return {HOUR_W'(h), MINF_W'(m % MIN_PER_HOUR)};
  endfunction

  // Interval: hours up to 600, minutes below
  function automatic logic [FIELD_W-1:0] ivField(input logic [MIN_W-1:0] m);
    return {IVH_W'(m / MIN_PER_HOUR), IVM_W'(m % MIN_PER_HOUR)};
  endfunction

  function automatic logic [MIN_W-1:0] satAdd(input logic [MIN_W-1:0] a, input logic [MIN_W-1:0] b);
    logic [MIN_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s >= {1'b0, SAT_MIN}) ? SAT_MIN : s[MIN_W-1:0];
  endfunction

endpackage

// [rtl/flh_time_acc.sv]
// Minute accumulator with registered years.days and hours.minutes views.
// Assumes a one-cycle minute tick from the parent's divider.
`timescale 1ns/1ps
`default_nettype none
module flh_time_acc (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Control
  input  wire logic                         minTick,
  input  wire logic                         run,
  input  wire logic                         clear,
  input  wire logic                         load,
  input  wire logic [flh_pkg::MIN_W-1:0]    loadVal,
  // Views
  output logic      [flh_pkg::MIN_W-1:0]    minutes,
  output logic      [flh_pkg::FIELD_W-1:0]  yd,
  output logic      [flh_pkg::FIELD_W-1:0]  hm
);
  logic [flh_pkg::MIN_W-1:0]   next_minutes;

  always_comb begin
    next_minutes = minutes;
    if (clear) begin
      next_minutes = '0;
    end else if (load) begin
      next_minutes = loadVal;
    end else if (run && minTick) begin
      next_minutes = minutes + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      minutes <= '0;
      yd      <= '0;
      hm      <= '0;
    end else begin
      minutes <= next_minutes;
      yd      <= flh_pkg::ydField(next_minutes);
      hm      <= flh_pkg::hmField(next_minutes);
    end
  end
endmodule
`default_nettype wire

// [rtl/flh_fault_logger.sv]
// Fault history and uptime logger: trip log, lifetime counters, slot errors.
// Assumes rst marks a power cycle and an external store returns saved counts on nvLoad.
//
// Overview of operation
// - keep exactly ten trips, newest first
// - new fault shifts history, oldest dropped
// - newest trip stamped with run time
// - run time counts only bridge enabled
// - times shown as years.days and hours.minutes
// - drive power-up timer restarts each power cycle
// - power-up count increments per power cycle
// - session time in tenth hours
// - total powered time kept, tenth hours
// - slot error code zero means none
// - slot errors at parameters 15.50-17.50
// - reset clears errors, live causes re-raise
// - older trips stored as interval to newest
// - intervals saturate at six hundred hours
`timescale 1ns/1ps
`default_nettype none
module flh_fault_logger #(
  parameter logic [31:0] CYC_PER_MIN = 32'(flh_pkg::CYC_PER_MIN)
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Saved lifetime values, restore and factory clear
  input  wire logic                          nvLoad,
  input  wire logic [flh_pkg::MIN_W-1:0]     nvCount,
  input  wire logic [flh_pkg::MIN_W-1:0]     nvTotal,
  input  wire logic [flh_pkg::MIN_W-1:0]     nvRun,
  input  wire logic                          factoryClr,
  // Drive status and faults
  input  wire logic                          bridgeEnabled,
  input  wire logic                          tripEvent,
  input  wire logic [flh_pkg::CODE_W-1:0]    tripCode,
  input  wire logic                          driveTripCause,
  input  wire logic [flh_pkg::CODE_W-1:0]    slot1Cause,
  input  wire logic [flh_pkg::CODE_W-1:0]    slot2Cause,
  input  wire logic [flh_pkg::CODE_W-1:0]    slot3Cause,
  input  wire logic                          errReset,
  // Parameter read port
  input  wire logic                          paramRd,
  input  wire logic [7:0]                    paramMenu,
  input  wire logic [7:0]                    paramIdx,
  output logic                               paramAck,
  output logic      [flh_pkg::FIELD_W-1:0]   paramData,
  // Trip history read port
  input  wire logic [3:0]                    tripSel,
  output logic      [flh_pkg::CODE_W-1:0]    histCode,
  output logic      [flh_pkg::FIELD_W-1:0]   histTime,
  // Lifetime views
  output logic                               ready,
  output logic      [flh_pkg::MIN_W-1:0]     powerUpCount,
  output logic      [flh_pkg::MIN_W-1:0]     sessionTenths,
  output logic      [flh_pkg::MIN_W-1:0]     totalTenths,
  output logic      [flh_pkg::FIELD_W-1:0]   drvUpYd,
  output logic      [flh_pkg::FIELD_W-1:0]   drvUpHm,
  output logic      [flh_pkg::FIELD_W-1:0]   runYd,
  output logic      [flh_pkg::FIELD_W-1:0]   runHm,
  output logic      [flh_pkg::FIELD_W-1:0]   trip0Yd,
  output logic      [flh_pkg::FIELD_W-1:0]   trip0Hm,
  // Error state
  output logic                               driveTripActive,
  output logic      [flh_pkg::CODE_W-1:0]    slotErr1,
  output logic      [flh_pkg::CODE_W-1:0]    slotErr2,
  output logic      [flh_pkg::CODE_W-1:0]    slotErr3,
  // Save record to the non-volatile store
  output logic                               nvWrStrobe,
  output logic                               nvWrBank,
  output logic      [flh_pkg::MIN_W-1:0]     nvWrCount,
  output logic      [flh_pkg::MIN_W-1:0]     nvWrTotal,
  output logic      [flh_pkg::MIN_W-1:0]     nvWrRun,
  output logic      [flh_pkg::MIN_W-1:0]     nvWrCheck
);
  localparam int D = flh_pkg::TRIP_DEPTH;
  localparam int S = flh_pkg::SLOTS;

  flh_pkg::flh_state_e          state, next_state;
  logic [31:0]                  cycCnt, next_cycCnt;
  logic [2:0]                   tenthCnt, next_tenthCnt;
  logic                         minTick, tenthTick;
  logic [flh_pkg::MIN_W-1:0]    next_powerUpCount, next_sessionTenths, next_totalTenths;
  logic [flh_pkg::MIN_W-1:0]    runMin;
  logic [flh_pkg::MIN_W-1:0]    runSave;
  logic [flh_pkg::CODE_W-1:0]   tripCodes [D], next_tripCodes [D];
  logic [flh_pkg::MIN_W-1:0]    tripIv [D], next_tripIv [D];
  logic [flh_pkg::MIN_W-1:0]    trip0Stamp, next_trip0Stamp;
  logic [flh_pkg::MIN_W-1:0]    delta;
  logic                         histAny, next_histAny;
  logic [flh_pkg::CODE_W-1:0]   cause [S], err [S], next_err [S];
  logic                         next_driveTripActive;
  logic                         commit, next_nvWrBank;

  assign cause[0] = slot1Cause;
  assign cause[1] = slot2Cause;
  assign cause[2] = slot3Cause;
  assign slotErr1 = err[0];
  assign slotErr2 = err[1];
  assign slotErr3 = err[2];
  assign ready    = (state == flh_pkg::ST_RUN);

  // ****************************************
  // Time base and lifetime counters
  // ****************************************
  assign minTick   = (cycCnt == CYC_PER_MIN - 1'b1);
  assign tenthTick = minTick && (tenthCnt == flh_pkg::MIN_PER_TENTH - 1'b1);
  // Counts persist across power cycles, so saves happen on restore, on each tenth tick and on factory clear
  assign commit    = (state == flh_pkg::ST_WAIT_NV && nvLoad) || (ready && (tenthTick || factoryClr));

  always_comb begin
    next_state         = state;
    next_cycCnt        = minTick ? '0 : cycCnt + 1'b1;
    next_tenthCnt      = tenthCnt;
    next_powerUpCount  = powerUpCount;
    next_sessionTenths = sessionTenths;
    next_totalTenths   = totalTenths;
    next_nvWrBank      = commit ? ~nvWrBank : nvWrBank;
    if (minTick) begin
      next_tenthCnt = tenthTick ? '0 : tenthCnt + 1'b1;
    end
    case (state)
      flh_pkg::ST_WAIT_NV: begin
        if (nvLoad) begin
          next_state        = flh_pkg::ST_RUN;
          next_powerUpCount = nvCount + 1'b1;
          next_totalTenths  = nvTotal;
        end
      end
      flh_pkg::ST_RUN: begin
        if (tenthTick) begin
          next_sessionTenths = sessionTenths + 1'b1;
          next_totalTenths   = totalTenths + 1'b1;
        end
        if (factoryClr) begin
          next_powerUpCount = '0;
          next_totalTenths  = '0;
        end
      end
      default: next_state = flh_pkg::ST_WAIT_NV;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state         <= flh_pkg::ST_WAIT_NV;
      cycCnt        <= '0;
      tenthCnt      <= '0;
      powerUpCount  <= '0;
      sessionTenths <= '0;
      totalTenths   <= '0;
      nvWrBank      <= 1'b0;
    end else begin
      state         <= next_state;
      cycCnt        <= next_cycCnt;
      tenthCnt      <= next_tenthCnt;
      powerUpCount  <= next_powerUpCount;
      sessionTenths <= next_sessionTenths;
      totalTenths   <= next_totalTenths;
      nvWrBank      <= next_nvWrBank;
    end
  end

  flh_time_acc u_drvUp (
    .clk     (clk),
    .rst     (rst),
    .minTick (minTick),
    .run     (1'b1),
    .clear   (1'b0),
    .load    (1'b0),
    .loadVal ('0),
    .minutes (),
    .yd      (drvUpYd),
    .hm      (drvUpHm)
  );

  flh_time_acc u_run (
    .clk     (clk),
    .rst     (rst),
    .minTick (minTick),
    .run     (ready && bridgeEnabled),
    .clear   (ready && factoryClr),
    .load    (!ready && nvLoad),
    .loadVal (nvRun),
    .minutes (runMin),
    .yd      (runYd),
    .hm      (runHm)
  );

  // ****************************************
  // Save record, alternating banks
  // ****************************************
  // Saved run time must match the value the accumulator takes at this edge
  assign runSave = !ready ? nvRun : (factoryClr ? '0 : runMin + flh_pkg::MIN_W'(bridgeEnabled && minTick));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvWrStrobe <= 1'b0;
      nvWrCount  <= '0;
      nvWrTotal  <= '0;
      nvWrRun    <= '0;
      nvWrCheck  <= '0;
    end else begin
      nvWrStrobe <= commit;
      if (commit) begin
        nvWrCount <= next_powerUpCount;
        nvWrTotal <= next_totalTenths;
        nvWrRun   <= runSave;
        nvWrCheck <= next_powerUpCount ^ next_totalTenths ^ runSave;
      end
    end
  end

  // ****************************************
  // Trip history
  // ****************************************
  // gap between old and new newest trip
  assign delta = histAny ? runMin - trip0Stamp : '0;

  always_comb begin
    next_trip0Stamp = trip0Stamp;
    next_histAny    = histAny;
    for (int i = 0; i < D; i++) begin
      next_tripCodes[i] = tripCodes[i];
      next_tripIv[i]    = tripIv[i];
    end
    if (tripEvent) begin
      for (int i = D - 1; i > 0; i--) begin
        next_tripCodes[i] = tripCodes[i-1];
        next_tripIv[i]    = (i == 1) ? flh_pkg::satAdd(delta, '0) : flh_pkg::satAdd(tripIv[i-1], delta);
      end
      next_tripCodes[0] = tripCode;
      next_tripIv[0]    = '0;
      next_trip0Stamp   = runMin;
      next_histAny      = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < D; i++) begin
        tripCodes[i] <= '0;
        tripIv[i]    <= '0;
      end
      trip0Stamp <= '0;
      histAny    <= 1'b0;
      trip0Yd    <= '0;
      trip0Hm    <= '0;
      histCode   <= '0;
      histTime   <= '0;
    end else begin
      for (int i = 0; i < D; i++) begin
        tripCodes[i] <= next_tripCodes[i];
        tripIv[i]    <= next_tripIv[i];
      end
      trip0Stamp <= next_trip0Stamp;
      histAny    <= next_histAny;
      trip0Yd    <= flh_pkg::ydField(next_trip0Stamp);
      trip0Hm    <= flh_pkg::hmField(next_trip0Stamp);
      histCode   <= (tripSel < 4'(D)) ? tripCodes[tripSel] : '0;
      histTime   <= (tripSel == 4'h0) ? flh_pkg::hmField(trip0Stamp)
                  : (tripSel < 4'(D)) ? flh_pkg::ivField(tripIv[tripSel]) : '0;
    end
  end

  // ****************************************
  // Active errors and parameter reads
  // ****************************************
  always_comb begin
    next_driveTripActive = driveTripActive || tripEvent || driveTripCause;
    if (errReset) begin
      next_driveTripActive = tripEvent || driveTripCause;
    end
    for (int i = 0; i < S; i++) begin
      next_err[i] = (err[i] != '0) ? err[i] : cause[i];
      if (errReset) begin
        next_err[i] = cause[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      driveTripActive <= 1'b0;
      for (int i = 0; i < S; i++) begin
        err[i] <= '0;
      end
      paramAck  <= 1'b0;
      paramData <= '0;
    end else begin
      driveTripActive <= next_driveTripActive;
      for (int i = 0; i < S; i++) begin
        err[i] <= next_err[i];
      end
      paramAck  <= paramRd;
      if (paramRd) begin
        paramData <= '0;
        if (paramIdx == flh_pkg::PARAM_ERR) begin
          case (paramMenu)
            flh_pkg::MENU_SLOT1: paramData <= {8'h00, err[0]};
            flh_pkg::MENU_SLOT2: paramData <= {8'h00, err[1]};
            flh_pkg::MENU_SLOT3: paramData <= {8'h00, err[2]};
            default:             paramData <= '0;
          endcase
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_shift; tripEvent |=> tripCodes[1] == $past(tripCodes[0]) && tripCodes[0] == $past(tripCode); endproperty
  a_shift: assert property (p_shift) else $error("History did not shift");
  property p_stamp; tripEvent |=> trip0Stamp == $past(runMin); endproperty
  a_stamp: assert property (p_stamp) else $error("Newest trip stamp wrong");
  property p_runhold; !bridgeEnabled && !factoryClr && ready |=> $stable(runMin); endproperty
  a_runhold: assert property (p_runhold) else $error("Run time moved with bridge off");
  property p_count; !ready && nvLoad |=> powerUpCount == $past(nvCount) + 1'b1 ##1 nvWrCount == powerUpCount; endproperty
  a_count: assert property (p_count) else $error("Power-up count not incremented");
  property p_session; ready && tenthTick |=> sessionTenths == $past(sessionTenths) + 1'b1; endproperty
  a_session: assert property (p_session) else $error("Session tenth missed");
  property p_total; ready && !tenthTick && !factoryClr |=> $stable(totalTenths); endproperty
  a_total: assert property (p_total) else $error("Total uptime changed without tick");
  property p_zero; errReset && slot1Cause == '0 |=> slotErr1 == '0; endproperty
  a_zero: assert property (p_zero) else $error("Slot error not cleared");
  property p_param; paramRd && paramMenu == flh_pkg::MENU_SLOT2 && paramIdx == flh_pkg::PARAM_ERR
    |=> paramAck && paramData == {8'h00, $past(slotErr2)}; endproperty
  a_param: assert property (p_param) else $error("Slot error parameter wrong");
  property p_reraise; errReset && slot3Cause != '0 |=> slotErr3 == $past(slot3Cause); endproperty
  a_reraise: assert property (p_reraise) else $error("Live error not raised again");
  property p_sat; tripIv[D-1] <= flh_pkg::SAT_MIN && tripIv[1] <= flh_pkg::SAT_MIN; endproperty
  a_sat: assert property (p_sat) else $error("Interval above saturation");
  property p_nv; nvWrStrobe |-> nvWrCheck == (nvWrCount ^ nvWrTotal ^ nvWrRun) && nvWrBank != $past(nvWrBank); endproperty
  a_nv: assert property (p_nv) else $error("Save record inconsistent");

  c_trip:   cover property (tripEvent ##1 tripEvent);
  c_reset:  cover property (errReset && slot1Cause != '0);
  c_commit: cover property (nvWrStrobe && ready);
endmodule
`default_nettype wire

// [bench/flh_nv_store.sv]
// Stand-in for the saved-value store on the far side of the logger.
// Assumes one restore pulse after each reset release and whole-record writes.
`timescale 1ns/1ps
`default_nettype none
module flh_nv_store #(
  parameter logic [31:0] INIT_COUNT = 32'h0000_0005,
  parameter logic [31:0] INIT_TOTAL = 32'h0000_0010,
  parameter logic [31:0] INIT_RUN   = 32'h0000_05DC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Record from the logger
  input  wire logic        nvWrStrobe,
  input  wire logic [31:0] nvWrCount,
  input  wire logic [31:0] nvWrTotal,
  input  wire logic [31:0] nvWrRun,
  input  wire logic [31:0] nvWrCheck,
  // Restore to the logger
  output logic             nvLoad,
  output logic      [31:0] nvCount,
  output logic      [31:0] nvTotal,
  output logic      [31:0] nvRun
);
  logic        loaded;
  logic [31:0] keepCount = INIT_COUNT;
  logic [31:0] keepTotal = INIT_TOTAL;
  logic [31:0] keepRun   = INIT_RUN;

  // One restore pulse per power cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nvLoad <= 1'b0;
      loaded <= 1'b0;
    end else begin
      nvLoad <= ~loaded;
      loaded <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (nvWrStrobe && nvWrCheck === (nvWrCount ^ nvWrTotal ^ nvWrRun)) begin
      keepCount <= nvWrCount;
      keepTotal <= nvWrTotal;
      keepRun   <= nvWrRun;
    end
  end

  // Lines carry junk outside the pulse, so stale values cannot pass
  assign nvCount = nvLoad ? keepCount : ~keepCount;
  assign nvTotal = nvLoad ? keepTotal : ~keepTotal;
  assign nvRun   = nvLoad ? keepRun : ~keepRun;
endmodule
`default_nettype wire

// [bench/flh_fault_logger_bench.sv]
// Self-checking bench for the fault logger, one task per scenario.
// Assumes flh_nv_store as the saved-value store and a short minute of 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin nErrors++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module flh_fault_logger_bench;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst, nvLoad, factoryClr, bridgeEnabled, tripEvent, driveTripCause, errReset, paramRd;
  logic        paramAck, ready, driveTripActive, nvWrStrobe, nvWrBank;
  logic [31:0] nvCount, nvTotal, nvRun, powerUpCount, sessionTenths, totalTenths;
  logic [31:0] nvWrCount, nvWrTotal, nvWrRun, nvWrCheck;
  logic [7:0]  tripCode, slot1Cause, slot2Cause, slot3Cause, paramMenu, paramIdx, histCode;
  logic [7:0]  slotErr1, slotErr2, slotErr3;
  logic [3:0]  tripSel;
  logic [15:0] paramData, histTime, drvUpYd, drvUpHm, runYd, runHm, trip0Yd, trip0Hm;
  int          nErrors = 0;
  int          nTests = 0;

  flh_fault_logger #(.CYC_PER_MIN(32'h0000_0014)) i_dut (
    .clk(clk), .rst(rst), .nvLoad(nvLoad), .nvCount(nvCount), .nvTotal(nvTotal), .nvRun(nvRun),
    .factoryClr(factoryClr), .bridgeEnabled(bridgeEnabled), .tripEvent(tripEvent), .tripCode(tripCode),
    .driveTripCause(driveTripCause), .slot1Cause(slot1Cause), .slot2Cause(slot2Cause), .slot3Cause(slot3Cause),
    .errReset(errReset), .paramRd(paramRd), .paramMenu(paramMenu), .paramIdx(paramIdx), .paramAck(paramAck),
    .paramData(paramData), .tripSel(tripSel), .histCode(histCode), .histTime(histTime), .ready(ready),
    .powerUpCount(powerUpCount), .sessionTenths(sessionTenths), .totalTenths(totalTenths), .drvUpYd(drvUpYd),
    .drvUpHm(drvUpHm), .runYd(runYd), .runHm(runHm), .trip0Yd(trip0Yd), .trip0Hm(trip0Hm),
    .driveTripActive(driveTripActive), .slotErr1(slotErr1), .slotErr2(slotErr2), .slotErr3(slotErr3),
    .nvWrStrobe(nvWrStrobe), .nvWrBank(nvWrBank), .nvWrCount(nvWrCount), .nvWrTotal(nvWrTotal),
    .nvWrRun(nvWrRun), .nvWrCheck(nvWrCheck));

  flh_nv_store i_store (
    .clk(clk), .rst(rst), .nvWrStrobe(nvWrStrobe), .nvWrCount(nvWrCount), .nvWrTotal(nvWrTotal),
    .nvWrRun(nvWrRun), .nvWrCheck(nvWrCheck), .nvLoad(nvLoad), .nvCount(nvCount), .nvTotal(nvTotal),
    .nvRun(nvRun));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic powerCycle();
    int k;
    @(posedge clk) rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 10 && ready !== 1'b1; k++) @(posedge clk);
    #1;
  endtask

  task automatic fireTrips(input logic [7:0] first, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) tripEvent <= 1'b1;
      tripCode <= first + 8'(i);
    end
    @(posedge clk) tripEvent <= 1'b0;
    #1;
  endtask

  task automatic readHist(input logic [3:0] idx, input logic [7:0] expCode, input logic [15:0] expTime);
    @(posedge clk) tripSel <= idx;
    @(posedge clk);
    #1;
    `CHK("histCode", expCode, histCode)
    `CHK("histTime", expTime, histTime)
  endtask

  task automatic readParam(input logic [7:0] menu, input logic [7:0] idx, input logic [15:0] exp);
    @(posedge clk) paramRd <= 1'b1;
    paramMenu <= menu;
    paramIdx <= idx;
    @(posedge clk) paramRd <= 1'b0;
    #1;
    `CHK("paramAck", 1'b1, paramAck)
    `CHK("paramData", exp, paramData)
  endtask

  task automatic pulseErrReset();
    @(posedge clk) errReset <= 1'b1;
    @(posedge clk) errReset <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testPowerUp();
    `CHK("ready", 1'b1, ready)
    `CHK("powerUpCount", 32'h0000_0006, powerUpCount)
    `CHK("runYd", 16'h0001, runYd)
    `CHK("runHm", 16'h0100, runHm)
    `CHK("nvWrCount", 32'h0000_0006, nvWrCount)
    `CHK("nvWrRun", 32'h0000_05DC, nvWrRun)
    `CHK("nvWrCheck", 32'h0000_05CA, nvWrCheck)
    `CHK("nvWrBank first", 1'b1, nvWrBank)
  endtask

  task automatic testTime();
    int k;
    for (k = 0; k < 200 && sessionTenths === 32'h0; k++) @(posedge clk);
    #1;
    `CHK("sessionTenths", 32'h0000_0001, sessionTenths)
    `CHK("totalTenths", 32'h0000_0011, totalTenths)
    `CHK("drvUpHm", 16'h0006, drvUpHm)
    `CHK("drvUpYd", 16'h0000, drvUpYd)
    `CHK("nvWrTotal", 32'h0000_0011, nvWrTotal)
    `CHK("nvWrBank second", 1'b0, nvWrBank)
    `CHK("runHm idle", 16'h0100, runHm)
  endtask

  task automatic testTrips();
    int k;
    fireTrips(8'h21, 1);
    `CHK("trip0Yd", 16'h0001, trip0Yd)
    `CHK("trip0Hm", 16'h0100, trip0Hm)
    `CHK("driveTripActive", 1'b1, driveTripActive)
    @(posedge clk) bridgeEnabled <= 1'b1;
    for (k = 0; k < 40 && runHm !== 16'h0101; k++) @(posedge clk);
    bridgeEnabled <= 1'b0;
    `CHK("runHm bridge", 16'h0101, runHm)
    fireTrips(8'h22, 1);
    readHist(4'h1, 8'h21, 16'h0001);
    // Back-to-back trips push the two above out of the log
    fireTrips(8'h30, 10);
    for (int i = 0; i < 10; i++) readHist(4'(i), 8'h39 - 8'(i), (i == 0) ? 16'h0101 : 16'h0000);
    readHist(4'hA, 8'h00, 16'h0000);
  endtask

  task automatic testErrors();
    @(posedge clk) slot1Cause <= 8'h05;
    slot2Cause <= 8'h07;
    repeat (2) @(posedge clk);
    #1;
    `CHK("slotErr1", 8'h05, slotErr1)
    `CHK("slotErr3", 8'h00, slotErr3)
    readParam(8'h0F, 8'h32, 16'h0005);
    readParam(8'h10, 8'h32, 16'h0007);
    readParam(8'h11, 8'h32, 16'h0000);
    readParam(8'h0F, 8'h31, 16'h0000);
    readParam(8'h12, 8'h32, 16'h0000);
    @(posedge clk) slot2Cause <= 8'h00;
    slot3Cause <= 8'h09;
    pulseErrReset();
    @(posedge clk);
    #1;
    `CHK("slotErr1 live", 8'h05, slotErr1)
    `CHK("slotErr2 gone", 8'h00, slotErr2)
    `CHK("slotErr3 live", 8'h09, slotErr3)
    `CHK("driveTripActive clr", 1'b0, driveTripActive)
    @(posedge clk) driveTripCause <= 1'b1;
    slot1Cause <= 8'h00;
    pulseErrReset();
    `CHK("driveTripActive live", 1'b1, driveTripActive)
    `CHK("slotErr1 cleared", 8'h00, slotErr1)
  endtask

  task automatic testFactory();
    @(posedge clk) factoryClr <= 1'b1;
    @(posedge clk) factoryClr <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("count cleared", 32'h0, powerUpCount)
    `CHK("runHm cleared", 16'h0000, runHm)
    powerCycle();
    `CHK("count after clear", 32'h0000_0001, powerUpCount)
    `CHK("drvUpHm restart", 16'h0000, drvUpHm)
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic completeRun();
    $display("errors %0d of %0d checks", nErrors, nTests);
    if (nErrors == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run needs about 220 cycles
  initial begin
    #(25 * 5000);
    nErrors++;
    completeRun();
  end

  initial begin
    rst = 1'b1;
    {factoryClr, bridgeEnabled, tripEvent, driveTripCause, errReset, paramRd} = '0;
    {tripCode, slot1Cause, slot2Cause, slot3Cause, paramMenu, paramIdx} = '0;
    tripSel = 4'h0;
    powerCycle();
    testPowerUp();
    testTime();
    testTrips();
    testErrors();
    testFactory();
    completeRun();
  end
endmodule
`default_nettype wire
